// ==== src/dram_ctrl_timing_config.sv ====
// Timing and configuration registers of the dynamic memory controller.
// Behaviour
// - Registers other than control state writable only in config or low-power.
// - Three-bit write-to-read delay, reset two.
// - Eight-bit power-down exit command time.
// - Eight-bit self-refresh command time, reset 0x14.
// - Two-bit pad read latency, reset zero.
// - Memory type field selects SDR/DDR/embedded/LPDDR.
// - Width field selects 16, 32, 64 bits.
// - Bit three sets clock-enable level after reset.
// - Bit two sets mask level after reset.
// - Outstanding refresh limit and prescaler value.
// - Eight masters with identifiers spaced 0x20.
// - Per-master enable, minimum and maximum priority.
// - Bit sixteen selects address organisation.
// - Chip selected by matching address bits 31:24.
// - Mask bits choose compared address bits.
//
// Our own choice: strobed register access.
`include "dram_timing_cfg.svh"
module dram_ctrl_timing_config #(
    parameter int QOS_DEPTH = 16
) (
    input  wire logic                        mclk,
    input  wire logic                        nrst,
    input  wire dram_timing_pkg::reg_req_t   regReq,
    output logic                      [31:0] regRdata,
    input  wire logic                 [31:0] busAddr,
    input  wire logic                 [2:0]  busMaster,
    output logic                             chipSelected,
    output logic                             orgBankFirst,
    output logic                             qosEnable,
    output logic                             qosMin,
    output logic                      [7:0]  qosMax,
    input  wire dram_timing_pkg::cmd_event_t cmdEvent,
    output logic                             readAllowed,
    output logic                             cmdAllowed,
    input  wire logic                        refreshTick,
    input  wire logic                        refreshIssued,
    output logic                             refreshDue,
    output logic                      [8:0]  prescaleValue,
    output logic                             memCke,
    output logic                             memDqm,
    output dram_timing_pkg::mem_setup_t      memSetup
);
    import dram_timing_pkg::*;

    // The QoS window decode is fixed at sixteen words.
    if (QOS_DEPTH != 16) begin : g_bad_depth
        $error("dram_ctrl_timing_config: QOS_DEPTH must be 16");
    end

    // ************************************************************
    // Register storage.
    // ************************************************************
    logic [2:0]  writeToRead_ff;   // Write-to-read delay.
    logic [7:0]  pdExit_ff;        // Power-down exit time.
    logic [7:0]  srExit_ff;        // Self-refresh exit time.
    logic [7:0]  srEntry_ff;       // Self-refresh command time.
    mem_setup_t  setup_ff;         // Memory setup fields.
    logic [11:0] refresh_ff;       // Prescaler and outstanding limit.
    logic [16:0] chip_ff;          // Chip select decode.
    ctrl_state_t state_ff;         // Controller state.
    logic [2:0]  outstanding_ff;   // Refreshes owed to the memory.
    logic [7:0]  gap_ff;           // Gap counter between dependent commands.
    logic        readGap_ff;       // Write-to-read gap in force.
    logic        rdPend_ff;        // Read answer in next cycle.
    logic        qosRd_ff;         // Answer comes from the QoS store.
    logic [31:0] rdHold_ff;        // Registered read data of plain registers.
    logic        memCke_ff;        // Clock-enable output level.
    logic        memDqm_ff;        // Mask output level.

    // Decoded access.
    logic cfgOpen;
    logic wrHit;
    logic qosHit;
    logic [9:0] qosRdData;
    logic [9:0] qosLook;

    // Access other than to control state is granted only in config or low-power state.
    assign cfgOpen = (state_ff == ST_CONFIG) || (state_ff == ST_LOWPWR);
    assign wrHit   = regReq.wr && cfgOpen;

    // Tells whether an address falls in the QoS window.
    function automatic logic isQos(input logic [11:0] a);
        isQos = (a >= `OFS_QOS_BASE) && (a <= `OFS_QOS_LAST) && (a[1:0] == 2'b00);
    endfunction : isQos

    assign qosHit = isQos(regReq.addr);

    // ************************************************************
    // Controller state, written through the control register.
    // ************************************************************
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= ST_CONFIG;
        end else if (regReq.wr && regReq.addr == `OFS_CONTROL_STATE) begin
            case (regReq.wdata[1:0])
                2'h0:    state_ff <= ST_CONFIG;
                2'h1:    state_ff <= ST_READY;
                2'h2:    state_ff <= ST_LOWPWR;
                default: state_ff <= state_ff;
            endcase
        end
    end

    // ************************************************************
    // Timing registers.
    // ************************************************************
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            writeToRead_ff <= `RST_WRITE_TO_READ;
            pdExit_ff      <= `RST_POWERDOWN_EXIT;
            srExit_ff      <= `RST_SELFREF_EXIT;
            srEntry_ff     <= `RST_SELFREF_ENTRY;
        end else if (wrHit) begin
            case (regReq.addr)
                `OFS_WRITE_TO_READ:  writeToRead_ff <= regReq.wdata[2:0];
                `OFS_POWERDOWN_EXIT: pdExit_ff      <= regReq.wdata[7:0];
                `OFS_SELFREF_EXIT:   srExit_ff      <= regReq.wdata[7:0];
                `OFS_SELFREF_ENTRY:  srEntry_ff     <= regReq.wdata[7:0];
                default: ;
            endcase
        end
    end

    // ************************************************************
    // Memory setup, refresh setup and chip decode registers.
    // ************************************************************
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            setup_ff   <= `RST_MEMORY_SETUP_TWO;
            refresh_ff <= `RST_REFRESH_SETUP;
            chip_ff    <= `RST_CHIP_DECODE;
        end else if (wrHit) begin
            case (regReq.addr)
                // Fields in bits 10:0; sync flags are software's duty.
                `OFS_MEMORY_SETUP_TWO: setup_ff <= regReq.wdata[10:0];
                `OFS_REFRESH_SETUP:    refresh_ff <= regReq.wdata[11:0];
                `OFS_CHIP_DECODE:      chip_ff <= regReq.wdata[16:0];
                default: ;
            endcase
        end
    end

    assign memSetup      = setup_ff;
    assign prescaleValue = refresh_ff[11:3];

    // ************************************************************
    // Clock-enable and mask outputs take their init levels in config.
    // ************************************************************
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            memCke_ff <= 1'b0;
            memDqm_ff <= 1'b0;
        end else if (state_ff == ST_CONFIG) begin
            memCke_ff <= setup_ff.ckeInit;
            memDqm_ff <= setup_ff.dqmInit;
        end else begin
            memCke_ff <= (state_ff == ST_READY);
            memDqm_ff <= 1'b0;
        end
    end

    assign memCke = memCke_ff;
    assign memDqm = memDqm_ff;

    // ************************************************************
    // Per-master QoS store, indexed by master identifier.
    // ************************************************************
    logic [3:0] qosWrIdx;
    logic [3:0] qosLookIdx;

    assign qosWrIdx   = regReq.addr[5:2];
    // Master identifier is busMaster times the stride; its entry index follows.
    assign qosLookIdx = {1'b0, busMaster};

    qos_store #(
        .DEPTH (QOS_DEPTH),
        .WIDTH (10)
    ) u_qos (
        .mclk     (mclk),
        .nrst     (nrst),
        .wrEn     (wrHit && qosHit),
        .wrIdx    (qosWrIdx),
        .wrData   (regReq.wdata[9:0]),
        .rdIdx    (qosWrIdx),
        .rdData   (qosRdData),
        .lookIdx  (qosLookIdx),
        .lookData (qosLook)
    );

    assign qosEnable = qosLook[0];
    assign qosMin    = qosLook[1];
    assign qosMax    = qosLook[9:2];

    // ************************************************************
    // Chip select decode and address organisation.
    // ************************************************************
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            chipSelected <= 1'b0;
            orgBankFirst <= 1'b0;
        end else begin
            chipSelected <= ((busAddr[31:24] ^ chip_ff[15:8]) & chip_ff[7:0]) == 8'h00;
            orgBankFirst <= chip_ff[16];
        end
    end

    // ************************************************************
    // Outstanding refresh tracking.
    // ************************************************************
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            outstanding_ff <= 3'h0;
        end else if (refreshTick && !refreshIssued) begin
            if (outstanding_ff < refresh_ff[2:0]) outstanding_ff <= outstanding_ff + 3'h1;
        end else if (refreshIssued && !refreshTick && outstanding_ff != 3'h0) begin
            outstanding_ff <= outstanding_ff - 3'h1;
        end
    end

    // Refresh must be forced once the limit is reached.
    assign refreshDue = (outstanding_ff != 3'h0) &&
                        (outstanding_ff >= refresh_ff[2:0]);

    // ************************************************************
    // Gaps between dependent commands.
    // ************************************************************
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            gap_ff     <= 8'h00;
            readGap_ff <= 1'b0;
        end else if (cmdEvent.selfrefEntry) begin
            gap_ff     <= srEntry_ff;
            readGap_ff <= 1'b0;
        end else if (cmdEvent.selfrefExit) begin
            gap_ff     <= srExit_ff;
            readGap_ff <= 1'b0;
        end else if (cmdEvent.powerdownExit) begin
            gap_ff     <= pdExit_ff;
            readGap_ff <= 1'b0;
        end else if (cmdEvent.writeDone) begin
            gap_ff     <= {5'h00, writeToRead_ff};
            readGap_ff <= 1'b1;
        end else if (gap_ff != 8'h00) begin
            gap_ff <= gap_ff - 8'h01;
        end else begin
            readGap_ff <= 1'b0;
        end
    end

    assign cmdAllowed  = (gap_ff == 8'h00) || readGap_ff;
    assign readAllowed = (gap_ff == 8'h00);

    // ************************************************************
    // Register read path, answer one cycle after the strobe.
    // ************************************************************
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdHold_ff <= 32'h0000_0000;
            rdPend_ff <= 1'b0;
            qosRd_ff  <= 1'b0;
        end else begin
            rdPend_ff <= regReq.rd;
            qosRd_ff  <= regReq.rd && qosHit && cfgOpen;
            rdHold_ff <= 32'h0000_0000;
            if (regReq.rd && regReq.addr == `OFS_CONTROL_STATE) begin
                rdHold_ff <= {29'h0, state_ff};
            end else if (regReq.rd && cfgOpen) begin
                case (regReq.addr)
                    `OFS_WRITE_TO_READ:    rdHold_ff <= {29'h0, writeToRead_ff};
                    `OFS_POWERDOWN_EXIT:   rdHold_ff <= {24'h0, pdExit_ff};
                    `OFS_SELFREF_EXIT:     rdHold_ff <= {24'h0, srExit_ff};
                    `OFS_SELFREF_ENTRY:    rdHold_ff <= {24'h0, srEntry_ff};
                    `OFS_MEMORY_SETUP_TWO: rdHold_ff <= {21'h0, setup_ff};
                    `OFS_REFRESH_SETUP:    rdHold_ff <= {20'h0, refresh_ff};
                    `OFS_CHIP_DECODE:      rdHold_ff <= {15'h0, chip_ff};
                    default:               rdHold_ff <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Read data are valid only in the cycle after the strobe.
    assign regRdata = !rdPend_ff ? 32'h0000_0000 :
                      qosRd_ff   ? {22'h0, qosRdData} : rdHold_ff;
endmodule : dram_ctrl_timing_config

// ==== src/dram_timing_cfg.svh ====
// Offsets, reset values and master stride of the timing and configuration block.
`ifndef DRAM_TIMING_CFG_SVH
`define DRAM_TIMING_CFG_SVH
`define OFS_WRITE_TO_READ      12'h03c
`define OFS_POWERDOWN_EXIT     12'h040
`define OFS_SELFREF_EXIT       12'h044
`define OFS_SELFREF_ENTRY      12'h048
`define OFS_MEMORY_SETUP_TWO   12'h04c
`define OFS_REFRESH_SETUP      12'h050
`define OFS_QOS_BASE           12'h100
`define OFS_QOS_LAST           12'h13c
`define OFS_CHIP_DECODE        12'h200
`define OFS_CONTROL_STATE      12'h300
`define RST_WRITE_TO_READ      3'h2
`define RST_POWERDOWN_EXIT     8'h01
`define RST_SELFREF_EXIT       8'h0a
`define RST_SELFREF_ENTRY      8'h14
`define RST_MEMORY_SETUP_TWO   11'h000
`define RST_REFRESH_SETUP      12'h000
`define RST_QOS                10'h000
`define RST_CHIP_DECODE        17'h0ff00
`define QOS_MASTER_STRIDE      8'h20
`endif

// ==== src/dram_timing_pkg.sv ====
// Types shared by the timing and configuration block.
package dram_timing_pkg;
    // Memory type selection.
    typedef enum logic [2:0] {
        MEM_SDR      = 3'h0,
        MEM_DDR      = 3'h1,
        MEM_EMBEDDED = 3'h2,
        MEM_LPDDR    = 3'h3
    } mem_type_t;

    // Controller operating states, one-hot.
    typedef enum logic [2:0] {
        ST_CONFIG = 3'b001,
        ST_READY  = 3'b010,
        ST_LOWPWR = 3'b100
    } ctrl_state_t;

    // Register bus request.
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    // Memory setup fields.
    typedef struct packed {
        logic [1:0] readDelay;
        logic [2:0] memType;
        logic [1:0] memWidth;
        logic       ckeInit;
        logic       dqmInit;
        logic       busFasterSynchronous;
        logic       clocksSynchronous;
    } mem_setup_t;

    // Dependent-command events that each start a gap timer.
    typedef struct packed {
        logic       writeDone;
        logic       powerdownExit;
        logic       selfrefExit;
        logic       selfrefEntry;
    } cmd_event_t;
endpackage : dram_timing_pkg

// ==== src/qos_store.sv ====
// Small register memory holding the per-master quality-of-service words.
module qos_store #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 10
) (
    input  wire logic                     mclk,
    input  wire logic                     nrst,
    input  wire logic                     wrEn,
    input  wire logic [$clog2(DEPTH)-1:0] wrIdx,
    input  wire logic [WIDTH-1:0]         wrData,
    input  wire logic [$clog2(DEPTH)-1:0] rdIdx,
    output logic      [WIDTH-1:0]         rdData,
    input  wire logic [$clog2(DEPTH)-1:0] lookIdx,
    output logic      [WIDTH-1:0]         lookData
);
    // Storage array.
    logic [WIDTH-1:0] mem_ff [DEPTH];

    // Refuses sizes that the index and data paths cannot serve.
    if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
        $error("qos_store: bad size");
    end

    // Writes update one entry; reset clears all entries.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < DEPTH; i++) mem_ff[i] <= '0;
        end else if (wrEn) begin
            mem_ff[wrIdx] <= wrData;
        end
    end

    // Read data come from a register.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdData   <= '0;
            lookData <= '0;
        end else begin
            rdData   <= mem_ff[rdIdx];
            lookData <= mem_ff[lookIdx];
        end
    end
endmodule : qos_store

// ==== tb/dram_ctrl_timing_config_asserts.sv ====
// Concurrent checks on the ports of the timing and configuration block.
module dram_ctrl_timing_config_asserts #(
    parameter int QOS_DEPTH = 16
) (
    input wire logic                        mclk,
    input wire logic                        nrst,
    input wire dram_timing_pkg::reg_req_t   regReq,
    input wire logic                 [31:0] regRdata,
    input wire dram_timing_pkg::cmd_event_t cmdEvent,
    input wire logic                        readAllowed,
    input wire logic                        cmdAllowed,
    input wire logic                        refreshTick,
    input wire logic                        refreshIssued,
    input wire logic                        refreshDue,
    input wire logic                 [8:0]  prescaleValue,
    input wire dram_timing_pkg::mem_setup_t memSetup,
    input wire logic                        orgBankFirst
);
    timeunit 1ns;
    timeprecision 1ps;
    import dram_timing_pkg::*;
    // ****************
    // Clock and reset
    // ****************
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // Read data is only driven in the answer cycle of a read.
    AST_READ_IDLE: assert property (!$past(regReq.rd) |-> regRdata == 32'h0)
        else $error("read data not zero outside the answer cycle");
    // Settings move only after a register write.
    AST_PRESCALE_HOLD: assert property (!$past(regReq.wr) |-> $stable(prescaleValue))
        else $error("prescaler value moved without a write");
    AST_SETUP_HOLD: assert property (!$past(regReq.wr) |-> $stable(memSetup))
        else $error("memory setup moved without a write");
    AST_ORG_HOLD: assert property (!$past(regReq.wr) && !$past(regReq.wr, 2) |->
        $stable(orgBankFirst)) else $error("address order moved without a write");
    // A write-to-read gap only blocks reads, never other commands.
    AST_WTR_ONLY: assert property (cmdEvent == 4'b1000 |=> cmdAllowed)
        else $error("write-to-read gap blocked commands");
    AST_GAP_ORDER: assert property (readAllowed |-> cmdAllowed)
        else $error("commands blocked while reads allowed");
    AST_GAP_CAUSE: assert property ($fell(readAllowed) |-> $past(|cmdEvent))
        else $error("gap started without a command event");
    // Owed refresh level changes only through ticks, payments or writes.
    AST_DUE_CLEAR: assert property ($fell(refreshDue) |->
        $past(refreshIssued) || $past(regReq.wr)) else $error("refresh due dropped unpaid");
    AST_DUE_RISE: assert property ($rose(refreshDue) |->
        $past(refreshTick) || $past(regReq.wr)) else $error("refresh due rose without a tick");
endmodule : dram_ctrl_timing_config_asserts

bind dram_ctrl_timing_config dram_ctrl_timing_config_asserts #(.QOS_DEPTH(QOS_DEPTH)) u_asserts (
    .mclk(mclk), .nrst(nrst), .regReq(regReq), .regRdata(regRdata), .cmdEvent(cmdEvent),
    .readAllowed(readAllowed), .cmdAllowed(cmdAllowed), .refreshTick(refreshTick),
    .refreshIssued(refreshIssued), .refreshDue(refreshDue), .prescaleValue(prescaleValue),
    .memSetup(memSetup), .orgBankFirst(orgBankFirst));

// ==== tb/mem_sched_model.sv ====
// Behavioural command scheduler at the far side: fires dependent-command and refresh pulses.
module mem_sched_model (
    input  wire logic                          mclk,
    input  wire logic                          nrst,
    input  wire dram_timing_pkg::cmd_event_t   evReq,
    input  wire logic                    [1:0] refReq,
    input  wire logic                          slow,
    output dram_timing_pkg::cmd_event_t        cmdEvent,
    output logic                               refreshTick,
    output logic                               refreshIssued
);
    timeunit 1ns;
    timeprecision 1ps;
    import dram_timing_pkg::*;
    cmd_event_t pendEv_ff; // Event waiting to be fired.
    logic [1:0] wait_ff;   // Cycles left before firing.
    // Latches a request, waits zero or three cycles, then fires it as a one-cycle pulse.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pendEv_ff <= '0;
            wait_ff   <= 2'h0;
            cmdEvent  <= '0;
        end else if (evReq != '0) begin
            pendEv_ff <= evReq;
            wait_ff   <= slow ? 2'h3 : 2'h0;
            cmdEvent  <= '0;
        end else if (pendEv_ff != '0 && wait_ff == 2'h0) begin
            cmdEvent  <= pendEv_ff;
            pendEv_ff <= '0;
        end else begin
            cmdEvent <= '0;
            wait_ff  <= (wait_ff != 2'h0) ? wait_ff - 2'h1 : 2'h0;
        end
    end
    // Refresh tick and payment pulses trail the request by one cycle.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            refreshTick   <= 1'b0;
            refreshIssued <= 1'b0;
        end else begin
            refreshTick   <= refReq[0];
            refreshIssued <= refReq[1];
        end
    end
endmodule : mem_sched_model

// ==== tb/tb_dram_ctrl_timing_config.sv ====
// Self-checking bench for the timing and configuration block.
module tb_dram_ctrl_timing_config;
    timeunit 1ns;
    timeprecision 1ps;
    import dram_timing_pkg::*;
    logic mclk, nrst, chipSelected, orgBankFirst, qosEnable, qosMin, readAllowed, cmdAllowed;
    logic refreshTick, refreshIssued, refreshDue, memCke, memDqm, slow;
    logic [31:0] regRdata, busAddr, d, cfg, a;
    logic [8:0]  prescaleValue;
    logic [7:0]  qosMax;
    logic [2:0]  busMaster;
    logic [1:0]  refReq;
    reg_req_t    regReq;
    cmd_event_t  evReq, cmdEvent;
    mem_setup_t  memSetup;
    int          bad_count, compares, n, c;
    logic [11:0] ofs    [8] = '{12'h03c, 12'h040, 12'h044, 12'h048, 12'h04c, 12'h050, 12'h100, 12'h200};
    logic [31:0] rstVal [8] = '{32'h2, 32'h1, 32'ha, 32'h14, 32'h0, 32'h0, 32'h0, 32'hff00};
    logic [31:0] msk    [8] = '{32'h7, 32'hff, 32'hff, 32'hff, 32'h7ff, 32'hfff, 32'h3ff, 32'h1ffff};

    dram_ctrl_timing_config #(.QOS_DEPTH(16)) u_dut (.mclk(mclk), .nrst(nrst), .regReq(regReq),
        .regRdata(regRdata), .busAddr(busAddr), .busMaster(busMaster),
        .chipSelected(chipSelected), .orgBankFirst(orgBankFirst), .qosEnable(qosEnable),
        .qosMin(qosMin), .qosMax(qosMax), .cmdEvent(cmdEvent), .readAllowed(readAllowed),
        .cmdAllowed(cmdAllowed), .refreshTick(refreshTick), .refreshIssued(refreshIssued),
        .refreshDue(refreshDue), .prescaleValue(prescaleValue), .memCke(memCke),
        .memDqm(memDqm), .memSetup(memSetup));
    mem_sched_model u_sched (.mclk(mclk), .nrst(nrst), .evReq(evReq), .refReq(refReq),
        .slow(slow), .cmdEvent(cmdEvent), .refreshTick(refreshTick),
        .refreshIssued(refreshIssued));

    // Expected chip selection: masked address bits must equal the match value.
    function automatic logic chip_exp(input logic [31:0] cf, input logic [31:0] ad);
        return ((ad[31:24] ^ cf[15:8]) & cf[7:0]) == 8'h0;
    endfunction : chip_exp
    // Counts a comparison and reports a mismatch.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One write cycle, then one idle edge so strobes never toggle twice at once.
    task automatic wr(input logic [11:0] ad, input logic [31:0] dat);
        regReq <= '{addr: ad, wdata: dat, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        regReq.wr <= 1'b0;
        @(posedge mclk);
    endtask : wr
    // One read cycle; data is sampled mid-way through the answer cycle.
    task automatic rc(input logic [11:0] ad, input logic [31:0] exp);
        regReq <= '{addr: ad, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        regReq.rd <= 1'b0;
        @(negedge mclk);
        chk(regRdata, exp);
        @(posedge mclk);
    endtask : rc
    // Requests a refresh pulse, then checks the owed-refresh flag.
    task automatic ref_pulse(input logic [1:0] r, input logic exp);
        refReq <= r;
        @(posedge mclk);
        refReq <= 2'b00;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk(32'(refreshDue), 32'(exp));
        @(posedge mclk);
    endtask : ref_pulse
    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    // Free-running clock, 8 ns period.
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // Watchdog cuts a hang short.
    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        $display("Watchdog expired");
        wrap_up();
    end
    // Main sequence.
    initial begin
        nrst = 1'b0; regReq = '0; busAddr = '0; busMaster = '0; evReq = '0; refReq = '0;
        slow = 1'b0; bad_count = 0; compares = 0;
        d = $urandom(43606);
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        for (int i = 0; i < 8; i++) rc(ofs[i], rstVal[i]);
        rc(12'h054, 32'h0);
        rc(12'h300, 32'h1);
        $display("Test reset values done");
        for (int i = 0; i < 24; i++) begin
            d = $urandom;
            wr(ofs[i % 8], d);
            rc(ofs[i % 8], d & msk[i % 8]);
        end
        $display("Test readback done");
        for (int k = 0; k < 12; k++) begin
            d = ($urandom & 32'h60f) | ((k % 4) << 6) | ((k / 4) << 4);
            wr(12'h04c, d);
            @(negedge mclk);
            chk(32'(memSetup), d[10:0]);
            chk({30'h0, memCke, memDqm}, d[3:2]);
            @(posedge mclk);
        end
        $display("Test memory setup done");
        for (int k = 0; k < 24; k++) begin
            cfg = (k < 3) ? 32'h0 : ($urandom & 32'h1ffff);
            wr(12'h200, cfg);
            a = $urandom;
            if (k % 2 == 1) a[31:24] = cfg[15:8] ^ (a[31:24] & ~cfg[7:0]);
            busAddr <= a;
            @(posedge mclk);
            @(negedge mclk);
            chk(32'(chipSelected), 32'(chip_exp(cfg, a)));
            chk(32'(orgBankFirst), 32'(cfg[16]));
            @(posedge mclk);
        end
        $display("Test chip decode done");
        for (int m = 0; m < 8; m++) begin
            d = $urandom & 32'h3ff;
            wr(12'h100 + 12'(m * 4), d);
            busMaster <= 3'(m);
            repeat (2) @(posedge mclk);
            @(negedge mclk);
            chk({22'h0, qosMax, qosMin, qosEnable}, d);
            @(posedge mclk);
        end
        $display("Test quality of service done");
        for (int k = 0; k < 8; k++) begin
            d = 1 + $urandom % 7;
            wr(ofs[k % 4], d);
            slow <= (k >= 4);
            evReq <= cmd_event_t'(4'b1000 >> (k % 4));
            @(posedge mclk);
            evReq <= '0;
            n = 0;
            c = 0;
            repeat (24) begin
                @(negedge mclk);
                n += int'(!readAllowed);
                c += int'(!cmdAllowed);
            end
            chk(32'(n), d);
            chk(32'(c), (k % 4 == 0) ? 32'h0 : d);
            @(posedge mclk);
        end
        $display("Test command gaps done");
        wr(12'h050, {20'h0, 9'h1a5, 3'h2});
        chk(32'(prescaleValue), 32'h1a5);
        ref_pulse(2'b01, 1'b0);
        ref_pulse(2'b01, 1'b1);
        ref_pulse(2'b01, 1'b1);
        ref_pulse(2'b10, 1'b0);
        $display("Test refresh done");
        wr(12'h03c, 32'h5);
        wr(12'h300, 32'h1);
        wr(12'h03c, 32'h3);
        rc(12'h03c, 32'h0);
        rc(12'h300, 32'h2);
        @(negedge mclk);
        chk({30'h0, memCke, memDqm}, 32'h2);
        @(posedge mclk);
        wr(12'h300, 32'h2);
        rc(12'h03c, 32'h5);
        wr(12'h03c, 32'h6);
        rc(12'h03c, 32'h6);
        chk(32'(memCke), 32'h0);
        wr(12'h300, 32'h0);
        rc(12'h300, 32'h1);
        nrst <= 1'b0;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        rc(12'h03c, 32'h2);
        $display("Test states and reset done");
        wrap_up();
    end
endmodule : tb_dram_ctrl_timing_config
